// File: verilog/cnpg_map.svh
// Purpose: named constants for the card and flash pin glue
// Assumes: 32-bit transfer address, 26-bit external address
// Notes:   definitions only
`ifndef CNPG_MAP_SVH
`define CNPG_MAP_SVH

// region decode on transfer address bits 31..28
`define CNPG_REGION_MSB     31
`define CNPG_REGION_LSB     28
`define CNPG_REGION_NAND    4'h4
`define CNPG_REGION_CARD_A  4'h5
`define CNPG_REGION_CARD_B  4'h6

// card mode field on transfer address bits 23..21
`define CNPG_MODE_MSB       23
`define CNPG_MODE_LSB       21
`define CNPG_CODE_ATTR      3'h0
`define CNPG_CODE_COMMON    3'h2
`define CNPG_CODE_IO        3'h4
`define CNPG_CODE_IDE       3'h6
`define CNPG_CODE_ALT_IDE   3'h7

// external address bits with a second use
`define CNPG_REG_BIT        22
`define CNPG_A25_BIT        25

// bus width field codes
`define CNPG_WIDTH_8        2'h0
`define CNPG_WIDTH_16       2'h1

// chip select pin positions
`define CNPG_SEL_NAND       3
`define CNPG_SEL_CARD_A     4
`define CNPG_SEL_CARD_B     5
`define CNPG_SEL_SIX        6
`define CNPG_SEL_SEVEN      7

// idle level of every active-low pin after reset
`define CNPG_PIN_IDLE       1'b1
`define CNPG_SEL_IDLE       8'hff
`define CNPG_DIR_RESET      1'b1
`define CNPG_ADDR_RESET     1'b0 // address, register select and status after reset

`endif

// File: verilog/cnpg_pkg.sv
// Purpose: types shared by the card and flash pin glue
// Assumes: nothing beyond the map header
// Notes:   mode codes are one-hot
package cnpg_pkg;

	// decoded card access mode
	typedef enum logic [5:0] {
		CNPG_MODE_NONE    = 6'h01,
		CNPG_MODE_ATTR    = 6'h02,
		CNPG_MODE_COMMON  = 6'h04,
		CNPG_MODE_IO      = 6'h08,
		CNPG_MODE_IDE     = 6'h10,
		CNPG_MODE_ALT_IDE = 6'h20
	} cnpg_mode_e;

	typedef logic [1:0] cnpg_width_t;

	// all registered pin state of the top module
	typedef struct packed {
		logic [7:0] sel_pins_n;
		logic       rd_pin_n;
		logic       wr0_pin_n;
		logic       byte_lane1_select_pin_n;
		logic       nbs3_pin_n;
		logic       a25_pin;
		logic       card_enable_low_n;
		logic       card_enable_high_n;
		logic       reg_select_pin;
		logic       card_access;
		logic       direction;
	} cnpg_state_s;

endpackage : cnpg_pkg

// File: verilog/cnpg_card_mode_dec.sv
// Purpose: card mode decode and card enable derivation
// Assumes: byte selects and chip select come straight from the controller
// Notes:   purely combinational; the top registers the results
`timescale 1ns/1ps
`default_nettype none
`include "cnpg_map.svh"

module cnpg_card_mode_dec
	import cnpg_pkg::*;
(
	// transfer side
	input  wire logic [2:0]  i_mode_bits,
	input  wire logic        i_space_hit,
	input  wire cnpg_width_t i_bus_width_field,
	// controller strobes, active low
	input  wire logic        i_chip_select_n,
	input  wire logic        i_byte_lane0_select_n,
	input  wire logic        i_byte_lane1_select_n,
	// decoded results
	output cnpg_mode_e       o_mode,
	output logic             o_card_enable_low_n,
	output logic             o_card_enable_high_n
);

	////////////////////////////////////////////////////////////////
	// mode decode, undecoded codes fall to none
	always_comb begin
		o_mode = CNPG_MODE_NONE;
		if (i_space_hit) begin
			case (i_mode_bits)
				`CNPG_CODE_ATTR:    o_mode = CNPG_MODE_ATTR;
				`CNPG_CODE_COMMON:  o_mode = CNPG_MODE_COMMON;
				`CNPG_CODE_IO:      o_mode = CNPG_MODE_IO;
				`CNPG_CODE_IDE:     o_mode = CNPG_MODE_IDE;
				`CNPG_CODE_ALT_IDE: o_mode = CNPG_MODE_ALT_IDE;
				default:            o_mode = CNPG_MODE_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// enables follow the chip select: a forced 0 becomes the select itself
	always_comb begin
		o_card_enable_high_n = `CNPG_PIN_IDLE;
		o_card_enable_low_n  = `CNPG_PIN_IDLE;
		case (o_mode)
			CNPG_MODE_ATTR: begin
				o_card_enable_high_n = i_byte_lane1_select_n | i_chip_select_n;
				o_card_enable_low_n  = i_byte_lane0_select_n | i_chip_select_n;
			end
			CNPG_MODE_COMMON, CNPG_MODE_IO: begin
				if (i_bus_width_field == `CNPG_WIDTH_8) begin
					o_card_enable_high_n = `CNPG_PIN_IDLE;
					o_card_enable_low_n  = i_chip_select_n;
				end else begin
					o_card_enable_high_n = i_byte_lane1_select_n | i_chip_select_n;
					o_card_enable_low_n  = i_byte_lane0_select_n | i_chip_select_n;
				end
			end
			CNPG_MODE_IDE: begin
				o_card_enable_high_n = `CNPG_PIN_IDLE;  // task file and data: high off
				o_card_enable_low_n  = i_chip_select_n;
			end
			CNPG_MODE_ALT_IDE: begin
				o_card_enable_high_n = i_chip_select_n;
				o_card_enable_low_n  = `CNPG_PIN_IDLE;
			end
			default: begin
				o_card_enable_high_n = `CNPG_PIN_IDLE;
				o_card_enable_low_n  = `CNPG_PIN_IDLE;
			end
		endcase
	end

endmodule : cnpg_card_mode_dec
`default_nettype wire

// File: verilog/cnpg_flash_gate.sv
// Purpose: gate controller strobes onto the flash strobe pins
// Assumes: strobes and chip select are active low
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cnpg_map.svh"

module cnpg_flash_gate (
	// configuration
	input  wire logic       i_assign_nand_space,
	// transfer side
	input  wire logic [3:0] i_region,
	input  wire logic       i_nand_select_line_n,
	input  wire logic       i_read_strobe_n,
	input  wire logic       i_write_strobe_low_n,
	// flash strobes, active low
	output logic            o_flash_read_strobe_n,
	output logic            o_flash_write_strobe_n
);

	logic active;

	////////////////////////////////////////////////////////////////
	// strobes pass only while the flash space is selected
	always_comb begin
		active = i_assign_nand_space & ~i_nand_select_line_n
			& (i_region == `CNPG_REGION_NAND);
		o_flash_read_strobe_n  = active ? i_read_strobe_n : `CNPG_PIN_IDLE;
		o_flash_write_strobe_n = active ? i_write_strobe_low_n : `CNPG_PIN_IDLE;
	end

endmodule : cnpg_flash_gate
`default_nettype wire

// File: verilog/card_nand_pin_glue.sv
// Purpose: pin glue for a removable memory card and a flash device
// Assumes: controller strobes and addresses synchronous to i_clk_sys
// Notes:   every pin output is registered, one cycle after its inputs
`timescale 1ns/1ps
`default_nettype none
`include "cnpg_map.svh"

// Behaviour
// - address bits 23..21 select card mode
// - address line 22 drives card register select outside IDE modes
// - slot assign bit dedicates select pin
// - attr and 16-bit common/io: enables follow byte selects
// - 8-bit common/io: high off, low on
// - alt IDE 0/1; idle or unassigned 1/1
// - card enables timed like card select
// - io and IDE strobes on io pins
// - memory modes strobes on memory pins
// - shared pins carry card signals only then
// - direction stable through whole transfer
// - slot buffer enable timed like select
// - flash assign enables third space logic
// - flash strobes only while flash selected
// - flash strobes replace selects six, seven
// - card spaces at 0x5 and 0x6 regions
module card_nand_pin_glue
	import cnpg_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// assignment bits
	input  wire logic        i_assign_nand_space,
	input  wire logic        i_assign_card_slot_a,
	input  wire logic        i_assign_card_slot_b,
	// chip select widths of the card spaces
	input  wire cnpg_width_t i_bus_width_field_a,
	input  wire cnpg_width_t i_bus_width_field_b,
	// transfer in progress
	input  wire logic [31:0] i_xfer_addr,
	input  wire logic        i_xfer_write,
	// controller pins, active low unless noted
	input  wire logic [7:0]  i_chip_select_n,
	input  wire logic        i_read_strobe_n,
	input  wire logic        i_write_strobe_low_n,
	input  wire logic        i_byte_lane0_select_n,
	input  wire logic        i_byte_lane1_select_n,
	input  wire logic        i_byte_lane3_select_n,
	input  wire logic [25:0] i_ext_addr,
	// device pins
	output wire logic [7:0]  o_select_pins_n,
	output wire logic        o_rd_pin_n,
	output wire logic        o_wr0_pin_n,
	output wire logic        o_byte_lane1_select_pin_n,
	output wire logic        o_nbs3_pin_n,
	output wire logic        o_a25_pin,
	output wire logic        o_reg_select_pin,
	output wire logic        o_card_enable_low_n,
	output wire logic        o_card_enable_high_n,
	// status
	output wire logic        o_card_access
);

	cnpg_state_s state_q;
	cnpg_state_s state_d;
	cnpg_mode_e  mode;
	cnpg_width_t width_sel;
	logic [3:0]  region;
	logic        hit_a;
	logic        hit_b;
	logic        card_cs_n;
	logic        ce_low_n;
	logic        ce_high_n;
	logic        flash_rd_n;
	logic        flash_wr_n;

	////////////////////////////////////////////////////////////////
	// card space decode, slot a wins if both match
	assign region    = i_xfer_addr[`CNPG_REGION_MSB:`CNPG_REGION_LSB];
	assign hit_a     = i_assign_card_slot_a & (region == `CNPG_REGION_CARD_A);
	assign hit_b     = i_assign_card_slot_b & (region == `CNPG_REGION_CARD_B);
	assign width_sel = hit_a ? i_bus_width_field_a : i_bus_width_field_b;
	assign card_cs_n = hit_a ? i_chip_select_n[`CNPG_SEL_CARD_A]
		: (hit_b ? i_chip_select_n[`CNPG_SEL_CARD_B] : `CNPG_PIN_IDLE);

	// mode and card enables
	cnpg_card_mode_dec u_mode_dec (
		.i_mode_bits           (i_xfer_addr[`CNPG_MODE_MSB:`CNPG_MODE_LSB]),
		.i_space_hit           (hit_a | hit_b),
		.i_bus_width_field     (width_sel),
		.i_chip_select_n       (card_cs_n),
		.i_byte_lane0_select_n (i_byte_lane0_select_n),
		.i_byte_lane1_select_n (i_byte_lane1_select_n),
		.o_mode                (mode),
		.o_card_enable_low_n   (ce_low_n),
		.o_card_enable_high_n  (ce_high_n)
	);

	// flash strobe gating
	cnpg_flash_gate u_flash_gate (
		.i_assign_nand_space    (i_assign_nand_space),
		.i_region               (region),
		.i_nand_select_line_n   (i_chip_select_n[`CNPG_SEL_NAND]),
		.i_read_strobe_n        (i_read_strobe_n),
		.i_write_strobe_low_n   (i_write_strobe_low_n),
		.o_flash_read_strobe_n  (flash_rd_n),
		.o_flash_write_strobe_n (flash_wr_n)
	);

	////////////////////////////////////////////////////////////////
	// next pin state
	always_comb begin
		state_d = state_q;
		state_d.card_access        = (mode != CNPG_MODE_NONE);
		state_d.card_enable_low_n  = ce_low_n;
		state_d.card_enable_high_n = ce_high_n;

		// direction caught on the first cycle of an access, then held
		if (state_d.card_access && !state_q.card_access) begin
			state_d.direction = ~i_xfer_write;
		end

		// select pins: dedicated or ordinary
		state_d.sel_pins_n = i_chip_select_n;
		state_d.sel_pins_n[`CNPG_SEL_CARD_A] = i_chip_select_n[`CNPG_SEL_CARD_A];
		state_d.sel_pins_n[`CNPG_SEL_CARD_B] = i_chip_select_n[`CNPG_SEL_CARD_B];
		if (i_assign_nand_space) begin
			state_d.sel_pins_n[`CNPG_SEL_SIX]   = flash_rd_n;
			state_d.sel_pins_n[`CNPG_SEL_SEVEN] = flash_wr_n;
		end

		// shared pins default to the ordinary signals
		state_d.rd_pin_n       = i_read_strobe_n;
		state_d.wr0_pin_n      = i_write_strobe_low_n;
		state_d.byte_lane1_select_pin_n     = i_byte_lane1_select_n;
		state_d.nbs3_pin_n     = i_byte_lane3_select_n;
		state_d.a25_pin        = i_ext_addr[`CNPG_A25_BIT];
		state_d.reg_select_pin = i_ext_addr[`CNPG_REG_BIT];

		// card strobe steering
		case (mode)
			CNPG_MODE_ATTR, CNPG_MODE_COMMON: begin
				state_d.rd_pin_n   = i_read_strobe_n;
				state_d.wr0_pin_n  = i_write_strobe_low_n;
				state_d.byte_lane1_select_pin_n = `CNPG_PIN_IDLE;
				state_d.nbs3_pin_n = `CNPG_PIN_IDLE;
				state_d.a25_pin    = state_d.direction;
			end
			CNPG_MODE_IO: begin
				state_d.rd_pin_n   = `CNPG_PIN_IDLE;
				state_d.wr0_pin_n  = `CNPG_PIN_IDLE;
				state_d.byte_lane1_select_pin_n = i_read_strobe_n;
				state_d.nbs3_pin_n = i_write_strobe_low_n;
				state_d.a25_pin    = state_d.direction;
			end
			CNPG_MODE_IDE, CNPG_MODE_ALT_IDE: begin
				state_d.rd_pin_n       = ~`CNPG_PIN_IDLE;
				state_d.wr0_pin_n      = `CNPG_PIN_IDLE;
				state_d.byte_lane1_select_pin_n     = i_read_strobe_n;
				state_d.nbs3_pin_n     = i_write_strobe_low_n;
				state_d.a25_pin        = state_d.direction;
				state_d.reg_select_pin = `CNPG_PIN_IDLE;       // register select unused
			end
			default: begin
				state_d.card_access = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q.sel_pins_n         <= `CNPG_SEL_IDLE;
			state_q.rd_pin_n           <= `CNPG_PIN_IDLE;
			state_q.wr0_pin_n          <= `CNPG_PIN_IDLE;
			state_q.byte_lane1_select_pin_n         <= `CNPG_PIN_IDLE;
			state_q.nbs3_pin_n         <= `CNPG_PIN_IDLE;
			state_q.a25_pin            <= `CNPG_ADDR_RESET;
			state_q.card_enable_low_n  <= `CNPG_PIN_IDLE;
			state_q.card_enable_high_n <= `CNPG_PIN_IDLE;
			state_q.reg_select_pin     <= `CNPG_ADDR_RESET;
			state_q.card_access        <= `CNPG_ADDR_RESET;
			state_q.direction          <= `CNPG_DIR_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from the state register
	assign o_select_pins_n      = state_q.sel_pins_n;
	assign o_rd_pin_n           = state_q.rd_pin_n;
	assign o_wr0_pin_n          = state_q.wr0_pin_n;
	assign o_byte_lane1_select_pin_n         = state_q.byte_lane1_select_pin_n;
	assign o_nbs3_pin_n         = state_q.nbs3_pin_n;
	assign o_a25_pin            = state_q.a25_pin;
	assign o_reg_select_pin     = state_q.reg_select_pin;
	assign o_card_enable_low_n  = state_q.card_enable_low_n;
	assign o_card_enable_high_n = state_q.card_enable_high_n;
	assign o_card_access        = state_q.card_access;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	AST_IO_STROBES: assert property (
		mode == CNPG_MODE_IO |=> o_byte_lane1_select_pin_n == $past(i_read_strobe_n)
			&& o_nbs3_pin_n == $past(i_write_strobe_low_n) && o_rd_pin_n && o_wr0_pin_n)
		else $error("io mode strobes misrouted");

	AST_IDE_READ_LOW: assert property (
		mode == CNPG_MODE_IDE |=> !o_rd_pin_n && o_wr0_pin_n && o_card_access)
		else $error("ide mode memory pins wrong");

	AST_MEM_STROBES: assert property (
		(mode == CNPG_MODE_ATTR || mode == CNPG_MODE_COMMON)
			|=> o_rd_pin_n == $past(i_read_strobe_n) && o_byte_lane1_select_pin_n && o_nbs3_pin_n)
		else $error("memory mode strobes misrouted");

	AST_SHARED_PASS: assert property (
		mode == CNPG_MODE_NONE |=> o_a25_pin == $past(i_ext_addr[`CNPG_A25_BIT])
			&& o_byte_lane1_select_pin_n == $past(i_byte_lane1_select_n) && !o_card_access)
		else $error("shared pins not passing ordinary signals");

	AST_ALT_IDE_ENABLES: assert property (
		mode == CNPG_MODE_ALT_IDE && !card_cs_n |=> !o_card_enable_high_n && o_card_enable_low_n)
		else $error("alternate ide enables wrong");

	AST_IDLE_ENABLES: assert property (
		card_cs_n || mode == CNPG_MODE_NONE |=> o_card_enable_high_n && o_card_enable_low_n)
		else $error("card enables active while idle");

	AST_BYTE8_ENABLES: assert property (
		mode == CNPG_MODE_COMMON && width_sel == `CNPG_WIDTH_8 && !card_cs_n
			|=> o_card_enable_high_n && !o_card_enable_low_n)
		else $error("8-bit odd byte enables wrong");

	AST_DIR_HOLD: assert property (
		o_card_access && $past(o_card_access) |-> $stable(o_a25_pin))
		else $error("direction changed within transfer");

	AST_FLASH_GATE: assert property (
		i_assign_nand_space && region != `CNPG_REGION_NAND
			|=> o_select_pins_n[`CNPG_SEL_SIX] && o_select_pins_n[`CNPG_SEL_SEVEN])
		else $error("flash strobe outside flash space");

	AST_BUFFER_ENABLE: assert property (
		i_assign_card_slot_a |=> o_select_pins_n[`CNPG_SEL_CARD_A] == $past(i_chip_select_n[`CNPG_SEL_CARD_A]))
		else $error("slot buffer enable timing differs");

	////////////////////////////////////////////////////////////////
	// checks on decode, selects, enables and strobes

	AST_MODE_DECODE: assert property (
		(hit_a || hit_b)
			&& i_xfer_addr[`CNPG_MODE_MSB:`CNPG_MODE_LSB] == `CNPG_CODE_IO
			|-> mode == CNPG_MODE_IO)
		else $error("io code not decoded");

	AST_UNDECODED_IDLE: assert property (
		(hit_a || hit_b) && !(i_xfer_addr[`CNPG_MODE_MSB:`CNPG_MODE_LSB] inside {`CNPG_CODE_ATTR,
			`CNPG_CODE_COMMON, `CNPG_CODE_IO, `CNPG_CODE_IDE, `CNPG_CODE_ALT_IDE})
			|=> o_card_enable_high_n && o_card_enable_low_n && !o_card_access)
		else $error("undecoded code treated as card access");

	AST_REG_SELECT: assert property (
		mode != CNPG_MODE_IDE && mode != CNPG_MODE_ALT_IDE
			|=> o_reg_select_pin == $past(i_ext_addr[`CNPG_REG_BIT]))
		else $error("register select not following address");

	AST_SLOT_PINS: assert property (
		!i_assign_card_slot_a
			|=> o_select_pins_n[`CNPG_SEL_CARD_A] == $past(i_chip_select_n[`CNPG_SEL_CARD_A]))
		else $error("unassigned slot pin not an ordinary select");

	AST_BYTE16_ENABLES: assert property (
		!card_cs_n && (mode == CNPG_MODE_ATTR || (width_sel != `CNPG_WIDTH_8
			&& (mode == CNPG_MODE_COMMON || mode == CNPG_MODE_IO)))
			|=> o_card_enable_high_n == $past(i_byte_lane1_select_n)
			&& o_card_enable_low_n == $past(i_byte_lane0_select_n))
		else $error("enables not following byte selects");

	AST_IO8_ENABLES: assert property (
		mode == CNPG_MODE_IO && width_sel == `CNPG_WIDTH_8 && !card_cs_n
			|=> o_card_enable_high_n && !o_card_enable_low_n)
		else $error("8-bit io enables wrong");

	AST_IDE_ENABLES: assert property (
		mode == CNPG_MODE_IDE |=> o_card_enable_high_n
			&& o_card_enable_low_n == $past(card_cs_n))
		else $error("ide low enable not timed like select");

	AST_MEM_WRITE: assert property (
		mode == CNPG_MODE_ATTR || mode == CNPG_MODE_COMMON
			|=> o_wr0_pin_n == $past(i_write_strobe_low_n))
		else $error("memory write strobe misrouted");

	AST_FLASH_STROBES: assert property (
		i_assign_nand_space && region == `CNPG_REGION_NAND && !i_chip_select_n[`CNPG_SEL_NAND]
			|=> o_select_pins_n[`CNPG_SEL_SIX] == $past(i_read_strobe_n)
			&& o_select_pins_n[`CNPG_SEL_SEVEN] == $past(i_write_strobe_low_n))
		else $error("flash strobes not on pins six and seven");

	AST_PLAIN_SIX_SEVEN: assert property (
		!i_assign_nand_space |=> o_select_pins_n[`CNPG_SEL_SIX] == $past(i_chip_select_n[`CNPG_SEL_SIX])
			&& o_select_pins_n[`CNPG_SEL_SEVEN] == $past(i_chip_select_n[`CNPG_SEL_SEVEN]))
		else $error("selects six and seven altered without flash");

endmodule : card_nand_pin_glue
`default_nettype wire

// File: verification/cnpg_slot_flash_model.sv
// Purpose: card slot and flash device as seen from the glue pins
// Assumes: pins sampled on the system clock
// Notes:   flash words counted by latch enable class on strobe rise
`timescale 1ns/1ps
`default_nettype none

module cnpg_slot_flash_model (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// flash side
	input  wire logic        i_flash_write_strobe_n,
	input  wire logic        i_chip_enable_n,
	input  wire logic [25:0] i_ext_addr,
	// card side
	input  wire logic        i_card_enable_low_n,
	output logic             o_wait_input_n,
	// word counts
	output logic [7:0]       o_cmd_count,
	output logic [7:0]       o_addr_count,
	output logic [7:0]       o_data_count
);
////////////////////////////////////////
logic       we_q;
logic       ce_q;
logic [1:0] cls_q;
logic       ale;
logic       cle;

// latch enables wired to address lines
assign ale = i_ext_addr[22];
assign cle = i_ext_addr[21];

// word capture and card wait
always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
	if (!i_rst_n) begin
		we_q           <= 1'h1;
		ce_q           <= 1'h1;
		cls_q          <= 2'h0;
		o_wait_input_n <= 1'h1;
		o_cmd_count    <= 8'h0;
		o_addr_count   <= 8'h0;
		o_data_count   <= 8'h0;
	end else begin
		we_q <= i_flash_write_strobe_n;
		ce_q <= i_card_enable_low_n;
		// stretch the first cycle of each card access on the low enable
		o_wait_input_n <= !(ce_q && !i_card_enable_low_n);
		// word class taken again each cycle the strobe is low
		if (!i_flash_write_strobe_n)
			cls_q <= {ale, cle};
		// word taken on strobe rise, chip kept enabled by a port line
		if (we_q === 1'h0 && i_flash_write_strobe_n && !i_chip_enable_n) begin
			case (cls_q)
				2'h1: o_cmd_count <= o_cmd_count + 8'h1;
				2'h2: o_addr_count <= o_addr_count + 8'h1;
				default: o_data_count <= o_data_count + 8'h1;
			endcase
		end
	end
end

endmodule : cnpg_slot_flash_model
`default_nettype wire

// File: verification/test_card_nand_pin_glue.sv
// Purpose: self-checking bench for the card and flash pin glue
// Assumes: every pin registered one cycle after its inputs
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none

module test_card_nand_pin_glue
	import cnpg_pkg::*;
();
////////////////////////////////////////
logic        clk = 1'h0;
logic        rst_n = 1'h0;
logic        nand_on = 1'h0, slot_a = 1'h0, slot_b = 1'h0;
cnpg_width_t width_a = 2'h0, width_b = 2'h0;
logic [31:0] addr = 32'h0;
logic        write = 1'h0;
logic [7:0]  cs_n = 8'hff;
logic        rd_n = 1'h1, wr_n = 1'h1;
logic [2:0]  bs_n = 3'h7;
logic [7:0]  e_sel;
logic        e_rd, e_wr, e_b1, e_b3, e_a25, e_reg, e_lo, e_hi, e_acc;
logic        e_dir = 1'h1;
logic        prev_card = 1'h0;
int          n_mismatch = 0;
int          checks_done = 0;
wire logic [7:0] sel_n, cmd_cnt, adr_cnt, dat_cnt;
wire logic   rd_pin, wr0_pin, byte_lane1_select_pin, nbs3_pin, a25_pin, reg_pin, ce_lo_n, ce_hi_n, acc;

// 250 MHz system clock
always #2 clk = ~clk;

// design and far side
card_nand_pin_glue uut (
	.i_clk_sys(clk), .i_rst_n(rst_n), .i_assign_nand_space(nand_on),
	.i_assign_card_slot_a(slot_a), .i_assign_card_slot_b(slot_b),
	.i_bus_width_field_a(width_a), .i_bus_width_field_b(width_b),
	.i_xfer_addr(addr), .i_xfer_write(write), .i_chip_select_n(cs_n),
	.i_read_strobe_n(rd_n), .i_write_strobe_low_n(wr_n), .i_byte_lane0_select_n(bs_n[0]),
	.i_byte_lane1_select_n(bs_n[1]), .i_byte_lane3_select_n(bs_n[2]), .i_ext_addr(addr[25:0]),
	.o_select_pins_n(sel_n), .o_rd_pin_n(rd_pin), .o_wr0_pin_n(wr0_pin), .o_byte_lane1_select_pin_n(byte_lane1_select_pin),
	.o_nbs3_pin_n(nbs3_pin), .o_a25_pin(a25_pin), .o_reg_select_pin(reg_pin),
	.o_card_enable_low_n(ce_lo_n), .o_card_enable_high_n(ce_hi_n), .o_card_access(acc));
cnpg_slot_flash_model partner (
	.i_clk_sys(clk), .i_rst_n(rst_n), .i_flash_write_strobe_n(sel_n[7]),
	.i_chip_enable_n(1'h0), .i_ext_addr(addr[25:0]), .i_card_enable_low_n(ce_lo_n),
	.o_wait_input_n(), .o_cmd_count(cmd_cnt), .o_addr_count(adr_cnt), .o_data_count(dat_cnt));

// compare helpers
task automatic chk1(input string name, input logic exp, input logic got);
	checks_done++;
	if (got !== exp)
		begin n_mismatch++; $display("[ERR] %s expected %h seen %h", name, exp, got); end
endtask : chk1
task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
	checks_done++;
	if (got !== exp)
		begin n_mismatch++; $display("[ERR] %s expected %h seen %h", name, exp, got); end
endtask : chk8

// verdict and end of run
task automatic conclude;
	$display("checks %0d mismatches %0d", checks_done, n_mismatch);
	if (n_mismatch == 0 && checks_done > 0) begin
		$display("SIMULATION PASSED");
	end else begin
		$display("SIMULATION FAILED");
	end
	$finish;
endtask : conclude

// pin levels while reset is held
task automatic chk_reset;
	chk8("reset_selects", 8'hff, sel_n);
	chk8("reset_pins", 8'hf0, {rd_pin, wr0_pin, byte_lane1_select_pin, nbs3_pin, a25_pin, reg_pin, acc, 1'h0});
	chk1("reset_enable_low", 1'h1, ce_lo_n);
	chk1("reset_enable_high", 1'h1, ce_hi_n);
endtask : chk_reset

// one controller cycle, then check the registered pins
task automatic drive(input logic [31:0] a, input logic [7:0] c, input logic r, input logic w,
	input logic [2:0] b, input logic wt);
	logic [2:0]  m;
	logic        card, cs_c;
	cnpg_width_t wd;
	m = a[23:21];
	card = ((a[31:28] == 4'h5 && slot_a) || (a[31:28] == 4'h6 && slot_b)) && !(m inside {3'h1, 3'h3, 3'h5});
	wd = (a[31:28] == 4'h5) ? width_a : width_b;
	cs_c = (a[31:28] == 4'h5) ? c[4] : c[5];
	if (card && !prev_card) e_dir = !wt;
	prev_card = card;
	e_sel = c;
	if (nand_on) begin
		e_sel[6] = (a[31:28] == 4'h4 && !c[3]) ? r : 1'h1;
		e_sel[7] = (a[31:28] == 4'h4 && !c[3]) ? w : 1'h1;
	end
	{e_rd, e_wr, e_b1, e_b3, e_a25, e_reg, e_hi, e_lo} = {r, w, b[1], b[2], a[25], a[22], 2'h3};
	e_acc = card;
	if (card) begin
		e_a25 = e_dir;
		case (m)
			3'h0, 3'h2: {e_b1, e_b3} = 2'h3;
			3'h4: {e_rd, e_wr, e_b1, e_b3} = {2'h3, r, w};
			default: {e_rd, e_wr, e_b1, e_b3, e_reg} = {2'h1, r, w, 1'h1};
		endcase
		if (!cs_c) begin
			if (m == 3'h7) {e_hi, e_lo} = 2'h1;
			else if (m == 3'h6 || (m != 3'h0 && wd == 2'h0)) {e_hi, e_lo} = 2'h2;
			else {e_hi, e_lo} = b[1:0];
		end
	end
	addr = a;
	cs_n = c;
	rd_n = r;
	wr_n = w;
	bs_n = b;
	write = wt;
	@(posedge clk);
	@(negedge clk);
	chk8("select_pins", e_sel, sel_n);
	chk1("rd_pin", e_rd, rd_pin);
	chk1("wr0_pin", e_wr, wr0_pin);
	chk1("byte_lane1_select_pin", e_b1, byte_lane1_select_pin);
	chk1("nbs3_pin", e_b3, nbs3_pin);
	chk1("a25_pin", e_a25, a25_pin);
	chk1("reg_select", e_reg, reg_pin);
	chk1("enable_low", e_lo, ce_lo_n);
	chk1("enable_high", e_hi, ce_hi_n);
	chk1("card_access", e_acc, acc);
endtask : drive

task automatic idle;
	drive(32'h0, 8'hff, 1'h1, 1'h1, 3'h7, 1'h0);
endtask : idle

// test sequence
initial begin
	repeat (4) @(posedge clk);
	@(negedge clk);
	chk_reset();
	rst_n = 1'h1;
	slot_a = 1'h1;
	slot_b = 1'h1;
	width_a = 2'h1;
	nand_on = 1'h1;
	// every mode code on both slots, 16-bit read and 8-bit write
	for (int k = 0; k < 8; k++) begin
		drive({8'h50, k[2:0], 21'h0}, 8'hef, 1'h0, 1'h1, 3'h5, 1'h0);
		idle();
		drive({8'h62, k[2:0], 21'h0}, 8'hdf, 1'h1, 1'h0, 3'h4, 1'h1);
		idle();
	end
	// direction held while the write flag changes
	drive(32'h5080_0000, 8'hef, 1'h1, 1'h0, 3'h4, 1'h1);
	drive(32'h5080_0000, 8'hef, 1'h0, 1'h1, 3'h4, 1'h0);
	// address setup with select still high
	drive(32'h5040_0000, 8'hff, 1'h1, 1'h1, 3'h4, 1'h0);
	idle();
	// other device and an unassigned card space
	drive(32'h1200_0000, 8'hfd, 1'h0, 1'h1, 3'h2, 1'h0);
	slot_a = 1'h0;
	drive(32'h5040_0000, 8'hef, 1'h0, 1'h1, 3'h4, 1'h0);
	slot_a = 1'h1;
	// flash read, then address leaving the flash space
	drive(32'h4000_0000, 8'hf7, 1'h0, 1'h1, 3'h7, 1'h0);
	drive(32'h7000_0000, 8'hf7, 1'h0, 1'h1, 3'h7, 1'h0);
	// command, address and data words
	for (int k = 0; k < 3; k++) begin
		drive({8'h40, 3'h1 << k, 21'h0}, 8'hf7, 1'h1, 1'h0, 3'h7, 1'h1);
		drive({8'h40, 3'h1 << k, 21'h0}, 8'hf7, 1'h1, 1'h1, 3'h7, 1'h1);
	end
	idle();
	idle();
	chk8("cmd_words", 8'h1, cmd_cnt);
	chk8("addr_words", 8'h1, adr_cnt);
	chk8("data_words", 8'h1, dat_cnt);
	// flash unassigned: pins six and seven are plain selects
	nand_on = 1'h0;
	drive(32'h4000_0000, 8'h37, 1'h0, 1'h0, 3'h7, 1'h1);
	// reset in mid-run
	rst_n = 1'h0;
	#1;
	chk_reset();
	@(negedge clk);
	rst_n = 1'h1;
	prev_card = 1'h0;
	drive(32'h5080_0000, 8'hef, 1'h0, 1'h1, 3'h4, 1'h0);
	conclude();
end

// watchdog
initial begin
	repeat (4000) @(posedge clk);
	n_mismatch++;
	$display("[ERR] run_length expected done seen timeout");
	conclude();
end

endmodule : test_card_nand_pin_glue
`default_nettype wire
